/* File: dlpb_regs.svh */
// Offsets, fields, reset values and counts of the down-link packet builder
// Included by the core and the bench; the package holds the types
// Behaviour
// - First cycle bits 15:11 carry packet type
// - Window codes 00110/01110; space field selects dense
// - Only one mailbox command outstanding anywhere
// - Any mask combination; set bit blocks byte
// - Mailbox cycle one forces bits 13:12 to 10
// - Cycle two: link number, zeros, byte mask
// - Cycles 3-4 address low first; 7-8 zero
// - Cycles 5-6 write quadword, low longword first
// - Return cycle one marks 01, zero fields
// - Return echoes the request tag in 31:24
// - Good parity on every return cycle
// - Return data longwords ascending from cycle two
// - Bit 23 of return flags an error
// - Read error logs, interrupts, one-cycle return
// - Up-link or internal errors send no return
// - Contiguous valid cycles; valid low ends packet
// - Odd parity over the 32 data lines
`ifndef DLPB_REGS_SVH
`define DLPB_REGS_SVH
`define DLPB_OFS_CMD 8'h00
`define DLPB_OFS_STAT 8'h04
`define DLPB_OFS_MBCMD 8'h08
`define DLPB_OFS_MBLINK 8'h0C
`define DLPB_OFS_ADRLO 8'h10
`define DLPB_OFS_ADRHI 8'h14
`define DLPB_OFS_WDLO 8'h18
`define DLPB_OFS_WDHI 8'h1C
`define DLPB_OFS_DMAHDR 8'h20
`define DLPB_OFS_DMADAT 8'h24
`define DLPB_OFS_ERRLOG 8'h28
`define DLPB_OFS_IRQSTAT 8'h30
`define DLPB_OFS_IRQCLR 8'h34
`define DLPB_OFS_IRQEN 8'h38
`define DLPB_CMD_MBOX 0
`define DLPB_CMD_DMA 1
`define DLPB_CMD_DERR 2
`define DLPB_CMD_IERR 3
`define DLPB_MBOX_MARK 2'h2
`define DLPB_DMA_MARK 2'h1
`define DLPB_LEN_LW 3'h1
`define DLPB_LEN_QW 3'h2
`define DLPB_LEN_OW 3'h3
`define DLPB_LEN_HW 3'h0
`define DLPB_LEN_DHW 3'h4
`define DLPB_CYC_OW 5'h05
`define DLPB_CYC_HW 5'h09
`define DLPB_CYC_DHW 5'h11
`define DLPB_CYC_MBOX 5'h08
`define DLPB_CYC_ERR 5'h01
`define DLPB_RST_WORD 32'h0000_0000
`endif

/* File: dlpb_pkg.sv */
// Types shared by the down-link packet builder
// Assumes nothing beyond a SystemVerilog compiler
package dlpb_pkg;
  // Sequencer states
  typedef enum logic [0:0] {DLPB_IDLE = 1'b0, DLPB_SEND = 1'b1} dlpb_state_t;
  // Packet kinds
  typedef enum logic [1:0] {DLPB_MBOX = 2'b00, DLPB_DMA = 2'b01, DLPB_DERR = 2'b10} dlpb_kind_t;
endpackage

/* File: dlpb_irq_if.sv */
// Carrier between the core and its interrupt unit
// Assumes both ends on sys_clk
`timescale 1ns/1ps
`default_nettype none
interface dlpb_irq_if;
  logic [3:0] events; // One-cycle event pulses
  logic [3:0] clear; // One-cycle clear pulses
  logic [3:0] enable; // Enable register
  logic [3:0] status; // Sticky status
  logic line; // Interrupt level
  modport core (output events, output clear, output enable, input status, input line);
  modport unit (input events, input clear, input enable, output status, output line);
endinterface
`default_nettype wire

/* File: dlpb_sync.sv */
// Two-stage synchroniser with rising-edge detect
// Assumes an input from outside the sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module dlpb_sync (
  input wire logic sysClk,
  input wire logic arstN,
  input wire logic asyncIn,
  output logic riseOut
);
  logic s1_q; // First stage, read only by s2
  logic s2_q; // Second stage
  logic s3_q; // Edge history
  // Shift chain
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= asyncIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end
  // Rising edge from settled stages
  assign riseOut = s2_q & ~s3_q;
endmodule
`default_nettype wire

/* File: dlpb_irq.sv */
// Sticky interrupt status with enable and write-one clear
// Assumes event and clear pulses on sys_clk
`timescale 1ns/1ps
`default_nettype none
module dlpb_irq (
  input wire logic sysClk,
  input wire logic arstN,
  dlpb_irq_if.unit bus
);
  logic [3:0] status_q; // Sticky bits
  logic line_q; // Interrupt level
  // Set wins over clear
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      status_q <= 4'h0;
    end else begin
      status_q <= (status_q & ~bus.clear) | bus.events;
    end
  end
  // Level output from a flop
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      line_q <= 1'b0;
    end else begin
      line_q <= |(status_q & bus.enable);
    end
  end
  assign bus.status = status_q;
  assign bus.line = line_q;
  // Level follows enabled status
  irqLevel_a: assert property (@(posedge sysClk) disable iff (!arstN)
    ##1 line_q == |($past(status_q) & $past(bus.enable)))
    else $error("interrupt level wrong");
endmodule
`default_nettype wire

/* File: dlpb_top.sv */
// Down-link packet builder: mailbox, read-return and error packets
// Assumes classic Wishbone on sys_clk and a free link clock input
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dlpb_regs.svh"
module dlpb_top
  import dlpb_pkg::*;
(
  input wire logic sysClk,
  input wire logic arstN,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [7:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic downClkIn,
  input wire logic mboxStatusReturn,
  output logic [31:0] downDataLines,
  output logic downParityLine,
  output logic downValidStrobe,
  output logic irqLine
);
  // Byte-lane merge for register writes
  function automatic logic [31:0] selMerge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      selMerge[b*8 +: 8] = sel[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // Cycles of a read return, zero for an unknown code
  function automatic logic [4:0] lenCycles(input logic [2:0] len);
    unique case (len)
      `DLPB_LEN_LW, `DLPB_LEN_QW, `DLPB_LEN_OW: lenCycles = `DLPB_CYC_OW;
      `DLPB_LEN_HW: lenCycles = `DLPB_CYC_HW;
      `DLPB_LEN_DHW: lenCycles = `DLPB_CYC_DHW;
      default: lenCycles = 5'h00;
    endcase
  endfunction

  // Read-return header word
  function automatic logic [31:0] retHeader(input logic [7:0] tag,
      input logic err, input logic [2:0] len);
    retHeader = {tag, err, 9'h000, `DLPB_DMA_MARK, 1'b0, len, 8'h00};
  endfunction

  // Bus slave state
  logic ack_q; // Answer flop
  logic [31:0] rdat_q; // Read data flop
  logic access; // New request this cycle
  logic wrEn; // New write this cycle
  logic [31:0] rd; // Read mux
  // Software registers
  logic [31:0] mbCmd_q; // Remote-bus command
  logic [15:0] mbLink_q; // Link number and mask
  logic [31:0] adrLo_q; // Target address low
  logic [31:0] adrHi_q; // Target address high
  logic [31:0] wdLo_q; // Write data low
  logic [31:0] wdHi_q; // Write data high
  logic [10:0] dmaHdr_q; // Length code and tag
  logic [31:0] dataBuf_q [16]; // Return data longwords
  logic [3:0] wrIdx_q; // Next buffer slot
  logic [3:0] irqEn_q; // Interrupt enables
  logic [9:0] errLog_q; // Error log
  // Sequencer state
  dlpb_state_t state_q; // Idle or sending
  dlpb_kind_t kind_q; // Packet being sent
  logic [4:0] idx_q; // Next word index
  logic [4:0] cnt_q; // Words in packet
  logic mbOut_q; // Mailbox outstanding
  logic [4:0] sentIdx_q; // Index of word on lines
  // Output flops
  logic [31:0] data_q; // Link data
  logic par_q; // Link parity
  logic valid_q; // Link valid
  // Command decode
  logic cmdHit; // Command register written
  logic goMbox; // Mailbox requested
  logic goDma; // Read return requested
  logic goDerr; // Data-path read error
  logic goIerr; // Up-link or internal error
  logic idle; // Sequencer free
  logic takeMbox; // Mailbox accepted
  logic takeDma; // Return accepted
  logic takeDerr; // Error return accepted
  logic refused; // Request dropped
  logic linkRise; // Link clock edge
  logic lastWord; // Packet finished at edge
  logic [31:0] curWord; // Word for this index
  dlpb_irq_if irqBus ();

  // Link clock edge finder
  dlpb_sync linkSync (
    .sysClk(sysClk),
    .arstN(arstN),
    .asyncIn(downClkIn),
    .riseOut(linkRise)
  );

  // Interrupt unit
  dlpb_irq irqUnit (
    .sysClk(sysClk),
    .arstN(arstN),
    .bus(irqBus)
  );

  assign access = wbCyc & wbStb & ~ack_q;
  assign wrEn = access & wbWe;
  assign cmdHit = wrEn & (wbAdr == `DLPB_OFS_CMD) & wbSel[0];
  assign goMbox = cmdHit & wbDatIn[`DLPB_CMD_MBOX];
  assign goDma = cmdHit & wbDatIn[`DLPB_CMD_DMA];
  assign goDerr = cmdHit & wbDatIn[`DLPB_CMD_DERR];
  assign goIerr = cmdHit & wbDatIn[`DLPB_CMD_IERR];
  assign idle = (state_q == DLPB_IDLE);
  // Mailbox first, then return, then error return
  assign takeMbox = goMbox & idle & ~mbOut_q;
  assign takeDma = goDma & idle & ~goMbox & (lenCycles(dmaHdr_q[10:8]) != 5'h00);
  assign takeDerr = goDerr & idle & ~goMbox & ~goDma;
  assign refused = (goMbox | goDma | goDerr) & ~(takeMbox | takeDma | takeDerr);
  assign lastWord = (state_q == DLPB_SEND) & linkRise & (idx_q == cnt_q);

  // Interrupt hookup
  assign irqBus.events = {refused, goDerr | goIerr, mboxStatusReturn & mbOut_q, lastWord};
  assign irqBus.clear = (wrEn && wbAdr == `DLPB_OFS_IRQCLR && wbSel[0]) ? wbDatIn[3:0] : 4'h0;
  assign irqBus.enable = irqEn_q;
  assign irqLine = irqBus.line;

  // Bus answer, one cycle after the request
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access;
    end
  end

  // Read data captured with the answer
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      rdat_q <= `DLPB_RST_WORD;
    end else if (access & ~wbWe) begin
      rdat_q <= rd;
    end
  end

  // Read mux; unmapped and write-only read zero
  always_comb begin
    rd = 32'h0000_0000;
    unique case (wbAdr)
      `DLPB_OFS_STAT: rd = {26'h0, wrIdx_q, mbOut_q, ~idle};
      `DLPB_OFS_MBCMD: rd = mbCmd_q;
      `DLPB_OFS_MBLINK: rd = {16'h0000, mbLink_q};
      `DLPB_OFS_ADRLO: rd = adrLo_q;
      `DLPB_OFS_ADRHI: rd = adrHi_q;
      `DLPB_OFS_WDLO: rd = wdLo_q;
      `DLPB_OFS_WDHI: rd = wdHi_q;
      `DLPB_OFS_DMAHDR: rd = {21'h0, dmaHdr_q};
      `DLPB_OFS_ERRLOG: rd = {22'h0, errLog_q};
      `DLPB_OFS_IRQSTAT: rd = {28'h0, irqBus.status};
      `DLPB_OFS_IRQEN: rd = {28'h0, irqEn_q};
      default: rd = 32'h0000_0000;
    endcase
  end

  // Mailbox, return and interrupt-enable registers
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      mbCmd_q <= `DLPB_RST_WORD;
      mbLink_q <= 16'h0000;
      adrLo_q <= `DLPB_RST_WORD;
      adrHi_q <= `DLPB_RST_WORD;
      wdLo_q <= `DLPB_RST_WORD;
      wdHi_q <= `DLPB_RST_WORD;
      dmaHdr_q <= 11'h000;
      irqEn_q <= 4'h0;
    end else if (wrEn) begin
      unique case (wbAdr)
        `DLPB_OFS_MBCMD: mbCmd_q <= selMerge(mbCmd_q, wbDatIn, wbSel);
        `DLPB_OFS_MBLINK: mbLink_q <= 16'(selMerge({16'h0000, mbLink_q}, wbDatIn, wbSel));
        `DLPB_OFS_ADRLO: adrLo_q <= selMerge(adrLo_q, wbDatIn, wbSel);
        `DLPB_OFS_ADRHI: adrHi_q <= selMerge(adrHi_q, wbDatIn, wbSel);
        `DLPB_OFS_WDLO: wdLo_q <= selMerge(wdLo_q, wbDatIn, wbSel);
        `DLPB_OFS_WDHI: wdHi_q <= selMerge(wdHi_q, wbDatIn, wbSel);
        `DLPB_OFS_DMAHDR: dmaHdr_q <= 11'(selMerge({21'h0, dmaHdr_q}, wbDatIn, wbSel));
        `DLPB_OFS_IRQEN: irqEn_q <= wbSel[0] ? wbDatIn[3:0] : irqEn_q;
        default: irqEn_q <= irqEn_q;
      endcase
    end
  end

  // Return data buffer, filled in ascending order
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      wrIdx_q <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        dataBuf_q[i] <= `DLPB_RST_WORD;
      end
    end else if (wrEn && wbAdr == `DLPB_OFS_DMADAT) begin
      dataBuf_q[wrIdx_q] <= selMerge(dataBuf_q[wrIdx_q], wbDatIn, wbSel);
      wrIdx_q <= wrIdx_q + 4'h1;
    end else if (takeDma) begin
      wrIdx_q <= 4'h0;
    end
  end

  // Error log: tag and source of the last data-path or internal error
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      errLog_q <= 10'h000;
    end else if (goDerr) begin
      errLog_q <= {1'b0, 1'b1, dmaHdr_q[7:0]};
    end else if (goIerr) begin
      errLog_q <= {1'b1, 1'b0, dmaHdr_q[7:0]};
    end
  end

  // One mailbox outstanding until its status comes back
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      mbOut_q <= 1'b0;
    end else if (takeMbox) begin
      mbOut_q <= 1'b1;
    end else if (mboxStatusReturn) begin
      mbOut_q <= 1'b0;
    end
  end

  // Packet sequencer
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      state_q <= DLPB_IDLE;
      kind_q <= DLPB_MBOX;
      idx_q <= 5'h00;
      cnt_q <= 5'h00;
    end else begin
      unique case (state_q)
        DLPB_IDLE: begin
          idx_q <= 5'h00;
          if (takeMbox) begin
            state_q <= DLPB_SEND;
            kind_q <= DLPB_MBOX;
            cnt_q <= `DLPB_CYC_MBOX;
          end else if (takeDma) begin
            state_q <= DLPB_SEND;
            kind_q <= DLPB_DMA;
            cnt_q <= lenCycles(dmaHdr_q[10:8]);
          end else if (takeDerr) begin
            state_q <= DLPB_SEND;
            kind_q <= DLPB_DERR;
            cnt_q <= `DLPB_CYC_ERR;
          end
        end
        DLPB_SEND: begin
          // One word per link edge, no gaps
          if (lastWord) begin
            state_q <= DLPB_IDLE;
          end else if (linkRise) begin
            idx_q <= idx_q + 5'h01;
          end
        end
      endcase
    end
  end

  // Word for the current index
  always_comb begin
    curWord = 32'h0000_0000;
    if (kind_q == DLPB_MBOX) begin
      unique case (idx_q)
        5'h00: curWord = {mbCmd_q[31:14], `DLPB_MBOX_MARK, mbCmd_q[11:0]};
        5'h01: curWord = {mbLink_q[15:8], 16'h0000, mbLink_q[7:0]};
        5'h02: curWord = adrLo_q;
        5'h03: curWord = adrHi_q;
        5'h04: curWord = wdLo_q;
        5'h05: curWord = wdHi_q;
        default: curWord = 32'h0000_0000;
      endcase
    end else if (idx_q == 5'h00) begin
      curWord = retHeader(dmaHdr_q[7:0], kind_q == DLPB_DERR, dmaHdr_q[10:8]);
    end else begin
      curWord = dataBuf_q[4'(idx_q - 5'h01)];
    end
  end

  // Link output flops, changed only at link edges
  always_ff @(posedge sysClk or negedge arstN) begin
    if (!arstN) begin
      data_q <= `DLPB_RST_WORD;
      par_q <= 1'b1;
      valid_q <= 1'b0;
      sentIdx_q <= 5'h00;
    end else if (state_q == DLPB_SEND && linkRise) begin
      if (idx_q == cnt_q) begin
        valid_q <= 1'b0;
      end else begin
        data_q <= curWord;
        par_q <= ~^curWord;
        valid_q <= 1'b1;
        sentIdx_q <= idx_q;
      end
    end
  end

  assign wbAck = ack_q;
  assign wbDatOut = rdat_q;
  assign downDataLines = data_q;
  assign downParityLine = par_q;
  assign downValidStrobe = valid_q;

  default clocking @(posedge sysClk); endclocking
  default disable iff (!arstN);

  // Odd parity whenever valid
  oddParity_a: assert property (valid_q |-> ^{data_q, par_q})
    else $error("even parity on valid cycle");
  // Mailbox first word marked 10, never a window code
  mboxMark_a: assert property (valid_q && kind_q == DLPB_MBOX && sentIdx_q == 5'h00
    |-> data_q[13:12] == 2'b10)
    else $error("mailbox mark wrong");
  // Return first word type and zero fields
  retHeader_a: assert property (valid_q && kind_q != DLPB_MBOX && sentIdx_q == 5'h00
    |-> data_q[15:11] == 5'b00010 && data_q[22:14] == 9'h000 && data_q[7:0] == 8'h00)
    else $error("return header wrong");
  // Mailbox cycle two zero middle
  mboxLink_a: assert property (valid_q && kind_q == DLPB_MBOX && sentIdx_q == 5'h01
    |-> data_q[23:8] == 16'h0000)
    else $error("mailbox cycle two not zero");
  // Only one mailbox until status comes back
  oneMbox_a: assert property (mbOut_q && !mboxStatusReturn |=> mbOut_q && !takeMbox)
    else $error("second mailbox issued");
  // Valid falls only after the last word
  endOfPkt_a: assert property ($fell(valid_q) |-> $past(idx_q) == $past(cnt_q))
    else $error("packet cut short");
  // Error return is one cycle with flag set
  errReturn_a: assert property (valid_q && kind_q == DLPB_DERR
    |-> data_q[23] && cnt_q == 5'h01)
    else $error("error return malformed");
  // Internal error never starts a packet; a packet ending at the same edge is not a start
  noReturn_a: assert property (goIerr && idle && !goMbox && !goDma && !goDerr |=> idle)
    else $error("packet sent for internal error");
  // Bus answers in one cycle and drops after one
  busAck_a: assert property (access |=> ack_q ##1 !ack_q)
    else $error("bus answer timing wrong");
endmodule
`default_nettype wire

/* File: dlpb_adapter_model.sv */
// Adapter receive model: captures each down-link packet word by word
// Assumes the link clock is an input of both sides and data settles before its falling edge
`timescale 1ns/1ps
`default_nettype none
module dlpb_adapter_model (
  input wire logic downClkIn,
  input wire logic [31:0] downDataLines,
  input wire logic downParityLine,
  input wire logic downValidStrobe
);
  // Captured {parity, data} words, cleared by the bench per packet
  logic [32:0] words[$];
  // Packets closed by a falling valid strobe
  int nPkt = 0;
  // Sample mid-word on the falling link edge; mask, data and length kept raw
  always @(negedge downClkIn) begin
    if (downValidStrobe === 1'b1) begin
      words.push_back({downParityLine, downDataLines});
    end
  end
  // Valid dropping ends the packet
  always @(negedge downValidStrobe) begin
    nPkt++;
  end
endmodule
`default_nettype wire

/* File: dlpb_top_tb.sv */
// Self-checking bench for the down-link packet builder
// Assumes the design files and the adapter model compile before it
`timescale 1ns/1ps
`default_nettype none
`include "dlpb_regs.svh"
module dlpb_top_tb;
  logic sysClk = 1'b0; // 40 MHz system clock
  logic arstN = 1'b0; // Async reset, low active
  logic downClkIn = 1'b0; // 200 ns link clock
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatIn = 32'h0000_0000;
  logic mboxStatusReturn = 1'b0;
  logic [31:0] wbDatOut, downDataLines;
  logic wbAck, downParityLine, downValidStrobe, irqLine;
  int n_fail = 0;
  int check_count = 0;
  logic [31:0] lfsrQ = 32'hF5C1; // Random source state
  logic [31:0] rd, t, w; // Read data and scratch
  logic [31:0] e[$]; // Expected packet words
  logic [2:0] lenTab[5] = '{3'h1, 3'h2, 3'h3, 3'h0, 3'h4};
  int cycTab[5] = '{5, 5, 5, 9, 17};
  int k, j;

  // System clock
  always #12.5 sysClk = ~sysClk;
  // Link clock, offset from the system clock
  initial begin
    #37;
    forever #100 downClkIn = ~downClkIn;
  end

  dlpb_top uut (.sysClk(sysClk), .arstN(arstN), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
    .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut), .wbAck(wbAck),
    .downClkIn(downClkIn), .mboxStatusReturn(mboxStatusReturn), .downDataLines(downDataLines),
    .downParityLine(downParityLine), .downValidStrobe(downValidStrobe), .irqLine(irqLine));

  dlpb_adapter_model model (.downClkIn(downClkIn), .downDataLines(downDataLines),
    .downParityLine(downParityLine), .downValidStrobe(downValidStrobe));

  // Next random word
  function automatic logic [31:0] rnd();
    lfsrQ = {lfsrQ[30:0], lfsrQ[31] ^ lfsrQ[21] ^ lfsrQ[1] ^ lfsrQ[0]};
    return lfsrQ;
  endfunction

  // Expected read-return header word
  function automatic logic [31:0] ret_hdr(input logic [7:0] tag, input logic err, input logic [2:0] len);
    return {tag, err, 9'h000, 2'b01, 1'b0, len, 8'h00};
  endfunction

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compare seen against expected
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic Wishbone cycle; read data lands in rd
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int i;
    @(posedge sysClk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= 4'hF;
    wbDatIn <= dat;
    i = 0;
    do begin
      @(posedge sysClk);
      i++;
    end while (wbAck !== 1'b1 && i < 20);
    rd = wbDatOut;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    if (wbAck !== 1'b1) begin
      check(1'b0, 1'b1);
      tally_and_finish();
    end
  endtask

  // Start a packet and compare it with e
  task automatic send(input logic [31:0] cmd);
    int n;
    int i;
    model.words.delete();
    n = model.nPkt;
    wb(1'b1, `DLPB_OFS_CMD, cmd);
    for (i = 0; i < 4000 && model.nPkt == n; i++) @(posedge sysClk);
    check(33'(model.nPkt - n), 33'h1);
    if (model.nPkt == n) tally_and_finish();
    check(33'(model.words.size()), 33'(e.size()));
    for (i = 0; i < e.size() && i < model.words.size(); i++) begin
      check(model.words[i], {~^e[i], e[i]});
    end
    wb(1'b0, `DLPB_OFS_STAT, 32'h0);
    check(rd[0], 1'b0);
  endtask

  // Command that must send nothing
  task automatic expect_none(input logic [31:0] cmd);
    int n;
    n = model.nPkt;
    wb(1'b1, `DLPB_OFS_CMD, cmd);
    repeat (100) @(posedge sysClk);
    check(33'(model.nPkt - n), 33'h0);
  endtask

  // Mailbox with random fields; f lands in the forced bits of the command
  task automatic mbox(input logic [1:0] f);
    e.delete();
    w = rnd();
    w[13:12] = f;
    wb(1'b1, `DLPB_OFS_MBCMD, w);
    e.push_back({w[31:14], 2'b10, w[11:0]});
    w = rnd() >> 16;
    wb(1'b1, `DLPB_OFS_MBLINK, w);
    e.push_back({w[15:8], 16'h0000, w[7:0]});
    for (j = 0; j < 4; j++) begin
      w = rnd();
      wb(1'b1, `DLPB_OFS_ADRLO + 8'(j * 4), w);
      e.push_back(w);
    end
    e.push_back(32'h0000_0000);
    e.push_back(32'h0000_0000);
    send(32'h1);
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge sysClk);
    check({wbAck, downValidStrobe, irqLine, downParityLine}, 4'h1);
    check(downDataLines, 32'h0000_0000);
    repeat (8) @(posedge sysClk);
    arstN <= 1'b1;
    // Mailbox, then a second one refused while outstanding
    mbox(2'b00);
    wb(1'b0, `DLPB_OFS_STAT, 32'h0);
    check(rd[1:0], 2'b10);
    check(irqLine, 1'b0);
    expect_none(32'h1);
    wb(1'b0, `DLPB_OFS_IRQSTAT, 32'h0);
    check(rd[3:0], 4'h9);
    @(posedge sysClk);
    mboxStatusReturn <= 1'b1;
    @(posedge sysClk);
    mboxStatusReturn <= 1'b0;
    wb(1'b0, `DLPB_OFS_STAT, 32'h0);
    check(rd[1], 1'b0);
    wb(1'b1, `DLPB_OFS_IRQEN, 32'h2);
    repeat (2) @(posedge sysClk);
    check(irqLine, 1'b1);
    wb(1'b1, `DLPB_OFS_IRQCLR, 32'hF);
    wb(1'b0, `DLPB_OFS_IRQSTAT, 32'h0);
    check(rd[3:0], 4'h0);
    check(irqLine, 1'b0);
    mbox(2'b01);
    $display("test mailbox done");
    // Read returns of all five defined length codes
    for (k = 0; k < 5; k++) begin
      t = rnd();
      e.delete();
      e.push_back(ret_hdr(t[7:0], 1'b0, lenTab[k]));
      for (j = 0; j < 16; j++) begin
        w = rnd();
        wb(1'b1, `DLPB_OFS_DMADAT, w);
        if (j < cycTab[k] - 1) e.push_back(w);
      end
      wb(1'b1, `DLPB_OFS_DMAHDR, {21'h000000, lenTab[k], t[7:0]});
      send(32'h2);
    end
    $display("test read return done");
    // Data-path error: one flagged word, logged, interrupt
    wb(1'b1, `DLPB_OFS_IRQCLR, 32'hF);
    wb(1'b1, `DLPB_OFS_IRQEN, 32'h4);
    e.delete();
    e.push_back(ret_hdr(t[7:0], 1'b1, 3'h4));
    send(32'h4);
    wb(1'b0, `DLPB_OFS_ERRLOG, 32'h0);
    check(rd[8:0], {1'b1, t[7:0]});
    check(irqLine, 1'b1);
    // Internal error: logged, no packet
    expect_none(32'h8);
    wb(1'b0, `DLPB_OFS_ERRLOG, 32'h0);
    check(rd[9], 1'b1);
    // Undefined length code refused
    wb(1'b1, `DLPB_OFS_DMAHDR, {21'h000000, 3'h5, t[7:0]});
    expect_none(32'h2);
    wb(1'b0, `DLPB_OFS_IRQSTAT, 32'h0);
    check(rd[3:2], 2'b11);
    $display("test errors done");
    // Unmapped address reads zero
    wb(1'b1, 8'h3C, rnd());
    wb(1'b0, 8'h3C, 32'h0);
    check(rd, 32'h0000_0000);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
